// *** common/d3tx_regs.vh ***
// Register offsets, field positions, the control reset value and frame geometry of the DS3 transmit line output.
`ifndef D3TX_REGS_VH
`define D3TX_REGS_VH

// ==========================================================================
// Register offsets
// ==========================================================================
`define D3TX_ADDR_W 8
`define D3TX_CTRL_ADDR 8'h00
`define D3TX_STATUS_ADDR 8'h04
`define D3TX_FRAMES_ADDR 8'h08

// ==========================================================================
// Control register fields and reset value
// ==========================================================================
`define D3TX_CTRL_ATM_BIT 0
`define D3TX_CTRL_BIPOLAR_BIT 1
`define D3TX_CTRL_FALLING_BIT 2
`define D3TX_CTRL_OVH_SER_BIT 3
`define D3TX_CTRL_CLKSRC_BIT 4
`define D3TX_CTRL_W 5
`define D3TX_CTRL_RESET 5'h00

// ==========================================================================
// Status register fields
// ==========================================================================
`define D3TX_STAT_BLK_LSB 0
`define D3TX_STAT_SUBFR_LSB 4
`define D3TX_STAT_ROW_LSB 8
`define D3TX_STAT_POL_BIT 12

// ==========================================================================
// DS3 frame geometry
// ==========================================================================
`define D3TX_BLOCK_LAST 7'h54
`define D3TX_BLK_LAST 3'h7
`define D3TX_SUBFR_LAST 3'h6

// ==========================================================================
// PLCP frame geometry, counted in payload bits
// ==========================================================================
`define D3TX_PLCP_LAST 13'h1593
`define D3TX_PLCP_NIBBLE_START 13'h1590
`define D3TX_ROW_LAST 9'h1C7
`define D3TX_ROW_TRAILER 4'hC
`define D3TX_A1_END 9'h008
`define D3TX_A2_END 9'h010
`define D3TX_POH_START 9'h018
`define D3TX_POH_END 9'h020
`define D3TX_A1_BYTE 8'hF6
`define D3TX_A2_BYTE 8'h28

`endif

// *** rtl/d3tx_sync.v ***
// Two-stage synchroniser for a group of pin inputs.
`timescale 1ns/1ps
module d3tx_sync #(
   parameter WIDTH = 1
) (
   input wire clk,
   input wire sys_rst,
   input wire [WIDTH-1:0] asyncIn,
   output reg [WIDTH-1:0] syncOut
);

   reg [WIDTH-1:0] stage1;

   // ==========================================================================
   // Only the second stage is visible to the logic behind it.
   // ==========================================================================
   always @(posedge clk) begin
      if (sys_rst) begin
         stage1 <= {WIDTH{1'b0}};
         syncOut <= {WIDTH{1'b0}};
      end else begin
         stage1 <= asyncIn;
         syncOut <= stage1;
      end
   end

endmodule

// *** rtl/d3tx_line_out.v ***
// DS3 transmit line output, overhead slot strobes and PLCP path overhead port.
//
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "d3tx_regs.vh"

// Overview of operation
// - Overhead from serial input when configured.
// - Else overhead pin if enabled, else internal.
// - ATM mode: strobe marks final PLCP nibble.
// - Unipolar: positive rail carries whole stream.
// - Bipolar: positive rail marks positive pulses.
// - Bipolar: negative rail marks negative pulses.
// - Unipolar: negative rail marks frame end.
// - Unipolar: negative rail low elsewhere.
// - Frame start marks first Z6 bit.
// - Frame start only in ATM mode.
// - Insert enable selects external path overhead.
// - Path overhead clocked by device clock output.
// - Line clock out from selected source.
module d3tx_line_out (
   input wire clk,
   input wire sys_rst,
   input wire [`D3TX_ADDR_W-1:0] regAddr,
   input wire [31:0] regWrData,
   input wire regWr,
   input wire regRd,
   output reg [31:0] regRdData,
   input wire txInClock,
   input wire rxLineClock,
   input wire serialPayloadInput,
   input wire ovhSerialInput,
   input wire ovhInsertEnable,
   input wire pohSerialInput,
   input wire pohInsertEnable,
   output reg txLineClock,
   output reg lineRailPositive,
   output reg lineRailNegative,
   output reg ovhSlotStrobe,
   output reg pohInsertFrameStart,
   output reg pohSerialClock
);

   // ==========================================================================
   // Pin synchronisers
   // ==========================================================================
   wire [6:0] pinSync;

   d3tx_sync #(
      .WIDTH(7)
   ) pinSyncInst (
      .clk(clk),
      .sys_rst(sys_rst),
      .asyncIn({pohInsertEnable, pohSerialInput, ovhInsertEnable, ovhSerialInput,
                serialPayloadInput, rxLineClock, txInClock}),
      .syncOut(pinSync)
   );

   wire txInClockS = pinSync[0];
   wire rxLineClockS = pinSync[1];
   wire serialIn = pinSync[2];
   wire ovhIn = pinSync[3];
   wire ovhInsert = pinSync[4];
   wire pohIn = pinSync[5];
   wire pohInsert = pinSync[6];

   // ==========================================================================
   // Control register
   // ==========================================================================
   reg [`D3TX_CTRL_W-1:0] ctrl;
   wire atmMode = ctrl[`D3TX_CTRL_ATM_BIT];
   wire bipolar = ctrl[`D3TX_CTRL_BIPOLAR_BIT];
   wire fallingEdge = ctrl[`D3TX_CTRL_FALLING_BIT];
   wire ovhFromSerial = ctrl[`D3TX_CTRL_OVH_SER_BIT];
   wire clkFromRx = ctrl[`D3TX_CTRL_CLKSRC_BIT];

   // ==========================================================================
   // Line clock selection and edge detection
   // ==========================================================================
   reg selClkPrev;
   wire selClk = clkFromRx ? rxLineClockS : txInClockS;
   wire riseSeen = selClk & ~selClkPrev;
   wire fallSeen = ~selClk & selClkPrev;
   wire bitTick = fallingEdge ? fallSeen : riseSeen;

   // ==========================================================================
   // Frame counters and state
   // ==========================================================================
   reg [6:0] bitPos;
   reg [2:0] blkIdx;
   reg [2:0] subfrIdx;
   reg [12:0] plcpCount;
   reg [8:0] rowBit;
   reg [3:0] rowIdx;
   reg parityAcc;
   reg parityLast;
   reg amiPolarity;
   reg pohWindow;
   reg [15:0] frameCount;

   wire ovhSlot = (bitPos == 7'h00);
   wire blockEnd = (bitPos == `D3TX_BLOCK_LAST);
   wire frameEnd = blockEnd && (blkIdx == `D3TX_BLK_LAST) && (subfrIdx == `D3TX_SUBFR_LAST);
   wire inRows = (rowIdx != `D3TX_ROW_TRAILER);
   wire pohSlot = inRows && (rowBit >= `D3TX_POH_START) && (rowBit < `D3TX_POH_END);

   // ==========================================================================
   // Internally generated overhead bit for the current slot
   // ==========================================================================
   reg internalOh;
   always @* begin
      internalOh = 1'b0;
      case (blkIdx)
         3'h0: begin
            if (subfrIdx < 3'h2) begin
               internalOh = 1'b1;
            end else if (subfrIdx < 3'h4) begin
               internalOh = parityLast;
            end else begin
               internalOh = (subfrIdx == 3'h5);
            end
         end
         3'h1: internalOh = 1'b1;
         3'h7: internalOh = 1'b1;
         default: internalOh = 1'b0;
      endcase
   end

   // ==========================================================================
   // PLCP payload bit
   // ==========================================================================
   wire [7:0] a1Byte = `D3TX_A1_BYTE;
   wire [7:0] a2Byte = `D3TX_A2_BYTE;
   wire [2:0] framingBitSel = 3'h7 - rowBit[2:0];
   reg plcpBit;
   always @* begin
      plcpBit = serialIn;
      if (inRows && rowBit < `D3TX_A1_END) begin
         plcpBit = a1Byte[framingBitSel];
      end else if (inRows && rowBit < `D3TX_A2_END) begin
         plcpBit = a2Byte[framingBitSel];
      end else if (pohSlot) begin
         plcpBit = pohInsert ? pohIn : 1'b0;
      end
   end

   // ==========================================================================
   // Outbound bit selection
   // ==========================================================================
   reg lineBit;
   always @* begin
      lineBit = serialIn;
      if (ovhSlot) begin
         if (ovhFromSerial) begin
            lineBit = serialIn;
         end else if (ovhInsert) begin
            lineBit = ovhIn;
         end else begin
            lineBit = internalOh;
         end
      end else if (atmMode) begin
         lineBit = plcpBit;
      end
   end

   // ==========================================================================
   // Register bus
   // ==========================================================================
   always @(posedge clk) begin
      if (sys_rst) begin
         ctrl <= `D3TX_CTRL_RESET;
         regRdData <= 32'h0000_0000;
      end else begin
         if (regWr && regAddr == `D3TX_CTRL_ADDR) begin
            ctrl <= regWrData[`D3TX_CTRL_W-1:0];
         end
         regRdData <= 32'h0000_0000;
         if (regRd) begin
            case (regAddr)
               `D3TX_CTRL_ADDR: regRdData <= {27'h000_0000, ctrl};
               `D3TX_STATUS_ADDR: begin
                  regRdData <= {19'h0_0000, amiPolarity, rowIdx, 1'b0, subfrIdx, 1'b0, blkIdx};
               end
               `D3TX_FRAMES_ADDR: regRdData <= {16'h0000, frameCount};
               default: regRdData <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ==========================================================================
   // Line clock output and path overhead clock
   // ==========================================================================
   always @(posedge clk) begin
      if (sys_rst) begin
         selClkPrev <= 1'b0;
         txLineClock <= 1'b0;
         pohSerialClock <= 1'b0;
      end else begin
         selClkPrev <= selClk;
         txLineClock <= selClk;
         // clock pulses only in the path overhead byte
         pohSerialClock <= selClk & pohWindow & atmMode;
      end
   end

   // ==========================================================================
   // DS3 frame position
   // ==========================================================================
   always @(posedge clk) begin
      if (sys_rst) begin
         bitPos <= 7'h00;
         blkIdx <= 3'h0;
         subfrIdx <= 3'h0;
         parityAcc <= 1'b0;
         parityLast <= 1'b0;
         frameCount <= 16'h0000;
      end else if (bitTick) begin
         if (blockEnd) begin
            bitPos <= 7'h00;
            blkIdx <= blkIdx + 3'h1;
            if (blkIdx == `D3TX_BLK_LAST) begin
               subfrIdx <= (subfrIdx == `D3TX_SUBFR_LAST) ? 3'h0 : subfrIdx + 3'h1;
            end
         end else begin
            bitPos <= bitPos + 7'h01;
         end
         if (frameEnd) begin
            parityLast <= parityAcc ^ lineBit;
            parityAcc <= 1'b0;
            frameCount <= frameCount + 16'h0001;
         end else if (!ovhSlot) begin
            parityAcc <= parityAcc ^ lineBit;
         end
      end
   end

   // ==========================================================================
   // PLCP frame position, advanced on payload bits only
   // ==========================================================================
   always @(posedge clk) begin
      if (sys_rst) begin
         plcpCount <= 13'h0000;
         rowBit <= 9'h000;
         rowIdx <= 4'h0;
         pohWindow <= 1'b0;
      end else if (bitTick) begin
         pohWindow <= pohSlot && !ovhSlot;
         if (!ovhSlot) begin
            if (plcpCount == `D3TX_PLCP_LAST) begin
               plcpCount <= 13'h0000;
               rowBit <= 9'h000;
               rowIdx <= 4'h0;
            end else begin
               plcpCount <= plcpCount + 13'h0001;
               if (rowBit == `D3TX_ROW_LAST && inRows) begin
                  rowBit <= 9'h000;
                  rowIdx <= rowIdx + 4'h1;
               end else begin
                  rowBit <= rowBit + 9'h001;
               end
            end
         end
      end
   end

   // ==========================================================================
   // Line rails and strobes
   // ==========================================================================
   always @(posedge clk) begin
      if (sys_rst) begin
         lineRailPositive <= 1'b0;
         lineRailNegative <= 1'b0;
         ovhSlotStrobe <= 1'b0;
         pohInsertFrameStart <= 1'b0;
         amiPolarity <= 1'b0;
      end else if (bitTick) begin
         if (bipolar) begin
            lineRailPositive <= lineBit & ~amiPolarity;
            lineRailNegative <= lineBit & amiPolarity;
            if (lineBit) begin
               amiPolarity <= ~amiPolarity;
            end
         end else begin
            lineRailPositive <= lineBit;
            lineRailNegative <= frameEnd;
         end
         if (atmMode) begin
            ovhSlotStrobe <= (plcpCount >= `D3TX_PLCP_NIBBLE_START);
         end else begin
            ovhSlotStrobe <= blockEnd;
         end
         pohInsertFrameStart <= atmMode && !ovhSlot && rowIdx == 4'h0 && rowBit == `D3TX_POH_START;
      end
   end

endmodule

// *** dv/d3tx_line_out_sva.sv ***
// Port-level assertions for the DS3 transmit line output.
`timescale 1ns/1ps
`include "d3tx_regs.vh"
module d3tx_line_out_sva (
   input wire clk,
   input wire sys_rst,
   input wire [`D3TX_ADDR_W-1:0] regAddr,
   input wire [31:0] regWrData,
   input wire regWr,
   input wire regRd,
   input wire [31:0] regRdData,
   input wire txInClock,
   input wire rxLineClock,
   input wire txLineClock,
   input wire lineRailPositive,
   input wire lineRailNegative,
   input wire ovhSlotStrobe,
   input wire pohInsertFrameStart,
   input wire pohSerialClock
);
   // ==========================================================
   // Helper logic
   // ==========================================================
   // Mode changes disturb the bit in flight, so line checks wait until the setup is quiet.
   reg [4:0] ctrlCopy;
   reg [3:0] quietCnt;
   wire settled = (quietCnt == 4'hF);
   always @(posedge clk) begin
      if (sys_rst) begin
         ctrlCopy <= 5'h00;
         quietCnt <= 4'h0;
      end else if (regWr) begin
         quietCnt <= 4'h0;
         if (regAddr == `D3TX_CTRL_ADDR) ctrlCopy <= regWrData[4:0];
      end else if (!settled) quietCnt <= quietCnt + 4'h1;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // ==========================================================
   // Assertions
   // ==========================================================
   a_reset_quiet: assert property ($fell(sys_rst) |-> !(lineRailPositive | lineRailNegative | ovhSlotStrobe
      | pohInsertFrameStart | pohSerialClock | txLineClock) && regRdData == 32'h0000_0000)
      else $error("outputs not cleared by reset");
   a_read_stands: assert property (regRdData != 32'h0000_0000 |-> $past(regRd))
      else $error("read data outside its cycle");
   a_ctrl_readback: assert property (regRd && regAddr == `D3TX_CTRL_ADDR |=> regRdData == {27'h0, ctrlCopy})
      else $error("control readback wrong");
   a_unmapped_zero: assert property (regRd && regAddr != `D3TX_CTRL_ADDR && regAddr != `D3TX_STATUS_ADDR
      && regAddr != `D3TX_FRAMES_ADDR |=> regRdData == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_ovh_strobe_width: assert property (settled && !ctrlCopy[0] && $rose(ovhSlotStrobe) |->
      ovhSlotStrobe [*8] ##1 !ovhSlotStrobe) else $error("overhead strobe not one bit long");
   a_eof_width: assert property (settled && !ctrlCopy[1] && $rose(lineRailNegative) |->
      lineRailNegative [*8] ##1 !lineRailNegative) else $error("end of frame not one bit long");
   a_rails_exclusive: assert property (settled && ctrlCopy[1] |-> !(lineRailPositive && lineRailNegative))
      else $error("both rails pulsed together");
   a_poh_atm_only: assert property (settled && !ctrlCopy[0] |-> !pohInsertFrameStart && !pohSerialClock)
      else $error("path overhead port active outside ATM");
   a_poh_start_width: assert property ($rose(pohInsertFrameStart) |->
      pohInsertFrameStart [*8] ##1 !pohInsertFrameStart) else $error("frame start not one bit long");
   a_poh_clock_slot: assert property ($rose(pohInsertFrameStart) |-> ##[0:7] pohSerialClock)
      else $error("no path overhead clock in first bit");
   a_line_clock_src: assert property (settled |->
      txLineClock == (ctrlCopy[4] ? $past(rxLineClock, 3) : $past(txInClock, 3)))
      else $error("line clock not from selected source");
   c_clear_strobe: cover property (!ctrlCopy[0] && $rose(ovhSlotStrobe));
   c_atm_strobe: cover property (ctrlCopy[0] && $rose(ovhSlotStrobe));
   c_frame_end: cover property (!ctrlCopy[1] && $rose(lineRailNegative));
   c_poh_start: cover property ($rose(pohInsertFrameStart));
endmodule
bind d3tx_line_out d3tx_line_out_sva chk (.*);

// *** dv/d3tx_far_end.sv ***
// Far-end model: DS3 clock sources, serial payload source and path overhead source.
`timescale 1ns/1ps
module d3tx_far_end (
   input wire run,
   input wire payBit,
   input wire ovhBit,
   input wire pohBit,
   input wire ovhSlotStrobe,
   input wire txLineClock,
   output reg txInClock,
   output reg rxLineClock,
   output reg serialPayloadInput,
   output reg pohSerialInput
);
   // ==========================================================
   // Clock sources
   // ==========================================================
   // The transmit clock is held low until asked, so setup happens with no bits in flight.
   initial begin
      txInClock = 1'b0;
      serialPayloadInput = 1'b1;
      pohSerialInput = 1'b0;
      #7;
      forever begin
         #80;
         txInClock = run ? ~txInClock : 1'b0;
      end
   end
   initial begin
      rxLineClock = 1'b0;
      forever #100 rxLineClock = ~rxLineClock;
   end
   // ==========================================================
   // Serial sources
   // ==========================================================
   // overhead replaces payload.
   always @(posedge txInClock) serialPayloadInput <= ovhSlotStrobe ? ovhBit : payBit;
   always @(negedge txLineClock) pohSerialInput <= pohBit;
endmodule

// *** dv/d3tx_line_out_bench.sv ***
// Self-checking bench for the DS3 transmit line output.
`timescale 1ns/1ps
`include "d3tx_regs.vh"
module d3tx_line_out_bench;
   reg clk, sys_rst, regWr, regRd, ovhSerialInput, ovhInsertEnable, pohInsertEnable;
   reg run, payBit, ovhBit, pohBit, prevStb, prevNeg, prevPfs, lastRail;
   reg [7:0] regAddr;
   reg [31:0] regWrData;
   wire [31:0] regRdData;
   wire txInClock, rxLineClock, serialPayloadInput, pohSerialInput, txLineClock;
   wire lineRailPositive, lineRailNegative, ovhSlotStrobe, pohInsertFrameStart, pohSerialClock;
   integer nErrors, testsRun, i, bad, cntA, cntB, cntC;
   d3tx_line_out dut (.*);
   d3tx_far_end farEnd (.*);
   // ==========================================================
   // Tasks
   // ==========================================================
   task check(input [31:0] got, input [31:0] exp);
      begin
         testsRun = testsRun + 1;
         if (got !== exp) begin
            nErrors = nErrors + 1;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      begin
         regAddr <= a;
         regWrData <= d;
         regWr <= 1'b1;
         @(posedge clk);
         regWr <= 1'b0;
      end
   endtask
   task rd(input [7:0] a, input [31:0] exp);
      begin
         regAddr <= a;
         regRd <= 1'b1;
         @(posedge clk);
         regRd <= 1'b0;
         @(posedge clk);
         check(regRdData, exp);
      end
   endtask
   // Setup is done with the line clock stopped so no bit sees a half-written mode.
   task restart(input [31:0] c);
      begin
         run <= 1'b0;
         sys_rst <= 1'b1;
         repeat (4) @(posedge clk);
         sys_rst <= 1'b0;
         @(posedge clk);
         wr(`D3TX_CTRL_ADDR, c);
         repeat (20) @(posedge clk);
         run <= 1'b1;
         repeat (40) @(posedge clk);
         bad = 0;
         cntA = 0;
         cntB = 0;
         cntC = 0;
         {prevStb, prevNeg, prevPfs, lastRail} = 4'h0;
      end
   endtask
   task testDone;
      begin
         $display("errors=%0d checks=%0d", nErrors, testsRun);
         if (nErrors == 0 && testsRun > 0) $display("== PASSED ==");
         else $display("== FAILED ==");
         $finish;
      end
   endtask
   // ==========================================================
   // Clock, watchdog and tests
   // ==========================================================
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      #1_500_000;
      nErrors = nErrors + 1;
      testDone;
   end
   initial begin
      {sys_rst, regWr, regRd, run, payBit, ovhBit, pohBit} = 7'h4F;
      {ovhSerialInput, ovhInsertEnable, pohInsertEnable} = 3'h0;
      regAddr = 8'h00;
      regWrData = 32'h0000_0000;
      nErrors = 0;
      testsRun = 0;
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      rd(`D3TX_CTRL_ADDR, 32'h0000_0000);
      rd(`D3TX_STATUS_ADDR, 32'h0000_0000);
      rd(`D3TX_FRAMES_ADDR, 32'h0000_0000);
      wr(`D3TX_CTRL_ADDR, 32'hFFFF_FFFF);
      rd(`D3TX_CTRL_ADDR, 32'h0000_001F);
      wr(`D3TX_FRAMES_ADDR, 32'h0000_1234);
      rd(`D3TX_FRAMES_ADDR, 32'h0000_0000);
      wr(8'h0C, 32'hFFFF_FFFF);
      rd(8'h0C, 32'h0000_0000);
      run <= 1'b1;
      repeat (200) @(posedge clk);
      ovhInsertEnable <= 1'b1;
      restart(32'h0000_0008);
      for (i = 0; i < 200; i = i + 1) begin
         repeat (8) @(posedge clk);
         if (lineRailPositive !== 1'b1) bad = bad + 1;
      end
      check(bad, 0);
      restart(32'h0000_0000);
      for (i = 0; i < 200; i = i + 1) begin
         repeat (8) @(posedge clk);
         if (lineRailPositive !== ~prevStb) bad = bad + 1;
         if (ovhSlotStrobe) cntA = cntA + 1;
         prevStb = ovhSlotStrobe;
      end
      check(bad, 0);
      check(cntA, 2);
      restart(32'h0000_0002);
      for (i = 0; i < 200; i = i + 1) begin
         repeat (8) @(posedge clk);
         if (lineRailPositive && lineRailNegative) bad = bad + 1;
         else if (lineRailPositive || lineRailNegative) begin
            if (cntA != 0 && lineRailPositive == lastRail) bad = bad + 1;
            lastRail = lineRailPositive;
            cntA = cntA + 1;
         end
      end
      check(bad, 0);
      check(cntA > 150, 32'h0000_0001);
      ovhInsertEnable <= 1'b0;
      pohInsertEnable <= 1'b1;
      restart(32'h0000_0001);
      for (i = 0; i < 5650; i = i + 1) begin
         repeat (8) @(posedge clk);
         if (i == 3000) pohInsertEnable <= 1'b0;
         if (ovhSlotStrobe && !prevStb) cntA = cntA + 1;
         if (lineRailNegative && !prevNeg) cntB = cntB + 1;
         if (lineRailNegative) bad = bad + 1;
         if (pohInsertFrameStart && !prevPfs) begin
            cntC = cntC + 1;
            check(lineRailPositive, i < 3000);
         end
         {prevStb, prevNeg, prevPfs} = {ovhSlotStrobe, lineRailNegative, pohInsertFrameStart};
      end
      check(cntA, 1);
      check(cntB, 1);
      check(bad, 1);
      check(cntC, 2);
      rd(`D3TX_FRAMES_ADDR, 32'h0000_0001);
      testDone;
   end
endmodule
